// [verilog/umcs_map.vh]
// Register map, field positions and reset values of the modem control and status block
`ifndef UMCS_MAP_VH
`define UMCS_MAP_VH

// Word index of each register; byte address is four times the index
`define UMCS_IDX_MSB      17
`define UMCS_IDX_LSB      2
`define UMCS_IDX_MODEM_INPUT_STATE_CH0     16'hF4FE
`define UMCS_IDX_SCRATCH_CH0     16'hF4FF
`define UMCS_IDX_MODEM_INPUT_STATE_CH1     16'hF8FE
`define UMCS_IDX_SCRATCH_CH1     16'hF8FF
`define UMCS_IDX_INT_STAT 16'hF900
`define UMCS_IDX_INT_EN   16'hF901
`define UMCS_IDX_INT_CLR  16'hF902
`define UMCS_IDX_CFG      16'hF903

// Register offsets inside one channel group of eight
`define UMCS_OFF_BUF 3'h0
`define UMCS_OFF_IER 3'h1
`define UMCS_OFF_IIR 3'h2
`define UMCS_OFF_LCR 3'h3
`define UMCS_OFF_MCR 3'h4
`define UMCS_OFF_LSR 3'h5
`define UMCS_OFF_MSR 3'h6
`define UMCS_OFF_SCR 3'h7

// Handshake output control fields
`define UMCS_MCR_DTR  0
`define UMCS_MCR_RTS  1
`define UMCS_MCR_AUX_OUTPUT_ONE 2
`define UMCS_MCR_AUX_OUTPUT_TWO 3
`define UMCS_MCR_LOOP 4

// Line format, enable and line state fields
`define UMCS_LCR_DIVISOR_ACCESS_SELECT 7
`define UMCS_IER_RBF  0
`define UMCS_IER_TBE  1
`define UMCS_IER_RLS  2
`define UMCS_IER_MS   3
`define UMCS_LSR_ERR_HI 4
`define UMCS_LSR_ERR_LO 1

// Source identification codes
`define UMCS_IIR_MS   2'h0
`define UMCS_IIR_TBE  2'h1
`define UMCS_IIR_RBF  2'h2
`define UMCS_IIR_RLS  2'h3
`define UMCS_IIR_NONE 8'h01

// Reset values
`define UMCS_RST_BYTE 8'h00
`define UMCS_RST_PAIR 2'h0

// Bus responses
`define UMCS_RESP_OKAY   2'h0
`define UMCS_RESP_SLVERR 2'h2

`endif

// [verilog/umcs_modem_chan.v]
// One channel of modem input synchronisation, routing and change flags
`timescale 1ns/1ps
`include "umcs_map.vh"

module umcs_modem_chan (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Modem pins, active low, order {carrier, ring, set ready, clear to send}
  input  wire [3:0] pin_n,
  output reg        terminal_ready_n,
  output reg        request_to_send_n,
  // Control
  input  wire [4:0] ctrl,
  input  wire       intc_mode,
  input  wire       msr_read,
  // Status
  output wire [7:0] modem_input_state,
  output wire       modem_status_src,
  output wire       change_evt
);

  reg  [3:0] sync1_reg;
  reg  [3:0] sync2_reg;
  reg  [3:0] prev_reg;
  reg  [3:0] delta_reg;
  wire [3:0] state;
  wire [3:0] set_bits;
  wire [3:0] delta_next;
  wire       loop_mode;
  wire       dtr;
  wire       rts;

  assign loop_mode = ctrl[`UMCS_MCR_LOOP];
  assign dtr       = ctrl[`UMCS_MCR_DTR];
  assign rts       = ctrl[`UMCS_MCR_RTS];

  // Pins are ignored in both internal modes
  assign state = loop_mode ? {ctrl[`UMCS_MCR_AUX_OUTPUT_TWO], ctrl[`UMCS_MCR_AUX_OUTPUT_ONE], dtr, rts} :
                 intc_mode ? {dtr, 1'b0, dtr, rts} :
                             ~sync2_reg;

  // Ring flag only on pin rising, i.e. active state falling
  assign set_bits = {state[3] ^ prev_reg[3],
                     prev_reg[2] & ~state[2],
                     state[1] ^ prev_reg[1],
                     state[0] ^ prev_reg[0]};

  // Set wins over the read clear so no edge is lost
  assign delta_next = (msr_read ? 4'h0 : delta_reg) | set_bits;

  assign modem_input_state = {prev_reg, delta_reg};
  assign modem_status_src  = |delta_reg;
  assign change_evt        = |set_bits;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg         <= 4'hF;
      sync2_reg         <= 4'hF;
      prev_reg          <= 4'h0;
      delta_reg         <= 4'h0;
      terminal_ready_n  <= 1'b1;
      request_to_send_n <= 1'b1;
    end else begin
      sync1_reg         <= pin_n;
      sync2_reg         <= sync1_reg;
      prev_reg          <= state;
      delta_reg         <= delta_next;
      terminal_ready_n  <= loop_mode | ~dtr;
      request_to_send_n <= loop_mode | ~rts;
    end
  end

endmodule

// [verilog/umcs_top.v]
// Two-channel modem control, modem status and register file behind an AXI4-Lite slave
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "umcs_map.vh"

module umcs_top (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        nrst,
  // AXI4-Lite write address and data
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Modem pins, active low, one bit per channel
  input  wire [1:0]  carrier_detect_n,
  input  wire [1:0]  ring_indicator_n,
  input  wire [1:0]  data_set_ready_n,
  input  wire [1:0]  clear_to_send_n,
  output wire [1:0]  terminal_ready_n,
  output wire [1:0]  request_to_send_n,
  // Serial core side, byte or bit per channel (divisor 16 bits), channel 1 in the upper part
  input  wire [15:0] rx_data,
  input  wire [15:0] line_state,
  input  wire [1:0]  rx_buf_full,
  input  wire [1:0]  tx_buf_empty,
  output reg  [1:0]  rx_buf_read,
  output reg  [15:0] tx_data,
  output reg  [1:0]  tx_buf_write,
  output reg  [1:0]  loopback_active,
  output wire [31:0] divisor,
  output wire [15:0] line_format,
  // Interrupts
  output wire [1:0]  serial_irq_request,
  output wire        irq
);

  localparam NCH = 2;

  reg         rst_sync_reg;
  reg         rst_n;
  reg         aw_hold_reg;
  reg  [15:0] aw_idx_reg;
  reg         aw_hi_ok_reg;
  reg         w_hold_reg;
  reg  [7:0]  w_data_reg;
  reg         w_strb_reg;
  reg  [15:0] handshake_output_control_reg;
  reg  [15:0] line_format_reg;
  reg  [15:0] irq_enable_reg;
  reg  [15:0] scratch_reg;
  reg  [15:0] divisor_low_byte;
  reg  [15:0] divisor_high_byte;
  reg  [1:0]  serial_config_reg;
  reg  [1:0]  int_stat_reg;
  reg  [1:0]  int_en_reg;
  reg  [7:0]  rd_val;
  reg         rd_ok;
  reg  [1:0]  msr_rd;
  reg  [1:0]  rbr_rd;
  reg  [7:0]  irq_source_id_reg [0:NCH-1];
  reg  [3:0]  src;
  integer     c;

  wire        wr_fire;
  wire        wr_do;
  wire        wr_ok;
  wire        rd_take;
  wire [15:0] rd_idx;
  wire        rd_hi_ok;
  wire [15:0] grp0;
  wire [15:0] grp1;
  wire [1:0]  wr_hit;
  wire [1:0]  rd_hit;
  wire        wr_own;
  wire        rd_own;
  wire [15:0] modem_input_state_reg;
  wire [1:0]  ms_src;
  wire [1:0]  ms_evt;
  wire [1:0]  rls_src;

  // Reset release through two flops
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_sync_reg <= 1'b1;
      rst_n        <= rst_sync_reg;
    end
  end

  // Address decode; channel groups sit at the status register index less its offset
  assign grp0     = `UMCS_IDX_MODEM_INPUT_STATE_CH0;
  assign grp1     = `UMCS_IDX_MODEM_INPUT_STATE_CH1;
  assign rd_idx   = s_axi_araddr[`UMCS_IDX_MSB:`UMCS_IDX_LSB];
  assign rd_hi_ok = ~|s_axi_araddr[31:`UMCS_IDX_MSB+1];
  assign wr_hit   = {aw_idx_reg[15:3] == grp1[15:3], aw_idx_reg[15:3] == grp0[15:3]};
  assign rd_hit   = {rd_idx[15:3] == grp1[15:3], rd_idx[15:3] == grp0[15:3]};
  assign wr_own   = (aw_idx_reg == `UMCS_IDX_INT_STAT) | (aw_idx_reg == `UMCS_IDX_INT_EN) |
                    (aw_idx_reg == `UMCS_IDX_INT_CLR) | (aw_idx_reg == `UMCS_IDX_CFG);
  assign rd_own   = (rd_idx == `UMCS_IDX_INT_STAT) | (rd_idx == `UMCS_IDX_INT_EN) |
                    (rd_idx == `UMCS_IDX_INT_CLR) | (rd_idx == `UMCS_IDX_CFG);

  // Address and data are taken in either order; the write lands once both are held
  assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_reg & ~s_axi_bvalid;
  assign wr_fire       = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  assign wr_ok         = aw_hi_ok_reg & (|wr_hit | wr_own);
  assign wr_do         = wr_fire & wr_ok & w_strb_reg;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take       = s_axi_arvalid & s_axi_arready;

  // Per-channel modem logic
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : ch
      umcs_modem_chan u_modem (
        .sys_clk           (sys_clk),
        .rst_n             (rst_n),
        .pin_n             ({carrier_detect_n[g], ring_indicator_n[g],
                             data_set_ready_n[g], clear_to_send_n[g]}),
        .terminal_ready_n  (terminal_ready_n[g]),
        .request_to_send_n (request_to_send_n[g]),
        .ctrl              (handshake_output_control_reg[g*8+4:g*8]),
        .intc_mode         (serial_config_reg[g]),
        .msr_read          (msr_rd[g]),
        .modem_input_state (modem_input_state_reg[g*8+7:g*8]),
        .modem_status_src  (ms_src[g]),
        .change_evt        (ms_evt[g])
      );
      assign rls_src[g] = |line_state[g*8+`UMCS_LSR_ERR_HI:g*8+`UMCS_LSR_ERR_LO];
    end
  endgenerate

  // Source id and per-channel request, line status first and modem status last
  always @* begin
    src = 4'h0;
    for (c = 0; c < NCH; c = c + 1) begin
      src[`UMCS_IER_RBF] = rx_buf_full[c] & irq_enable_reg[c*8+`UMCS_IER_RBF];
      src[`UMCS_IER_TBE] = tx_buf_empty[c] & irq_enable_reg[c*8+`UMCS_IER_TBE];
      src[`UMCS_IER_RLS] = rls_src[c] & irq_enable_reg[c*8+`UMCS_IER_RLS];
      src[`UMCS_IER_MS]  = ms_src[c] & irq_enable_reg[c*8+`UMCS_IER_MS];
      if (src[`UMCS_IER_RLS])
        irq_source_id_reg[c] = {5'h00, `UMCS_IIR_RLS, 1'b0};
      else if (src[`UMCS_IER_RBF])
        irq_source_id_reg[c] = {5'h00, `UMCS_IIR_RBF, 1'b0};
      else if (src[`UMCS_IER_TBE])
        irq_source_id_reg[c] = {5'h00, `UMCS_IIR_TBE, 1'b0};
      else if (src[`UMCS_IER_MS])
        irq_source_id_reg[c] = {5'h00, `UMCS_IIR_MS, 1'b0};
      else
        irq_source_id_reg[c] = `UMCS_IIR_NONE;
    end
  end

  assign serial_irq_request[0] = ~irq_source_id_reg[0][0];
  assign serial_irq_request[1] = ~irq_source_id_reg[1][0];
  assign irq = |(int_stat_reg & int_en_reg);

  assign divisor     = {divisor_high_byte[15:8], divisor_low_byte[15:8],
                        divisor_high_byte[7:0], divisor_low_byte[7:0]};
  assign line_format = line_format_reg;

  // Read mux; buffer and modem status reads carry side effects only when taken
  always @* begin : rd_mux
    integer c;
    c      = 0;
    rd_val = 8'h00;
    rd_ok  = rd_hi_ok & (|rd_hit | rd_own);
    msr_rd = 2'h0;
    rbr_rd = 2'h0;
    for (c = 0; c < NCH; c = c + 1) begin
      if (rd_hit[c]) begin
        case (rd_idx[2:0])
          `UMCS_OFF_BUF: begin
            if (line_format_reg[c*8+`UMCS_LCR_DIVISOR_ACCESS_SELECT]) begin
              rd_val = divisor_low_byte[c*8+:8];
            end else begin
              rd_val    = rx_data[c*8+:8];
              rbr_rd[c] = rd_take & rd_hi_ok;
            end
          end
          `UMCS_OFF_IER: begin
            if (line_format_reg[c*8+`UMCS_LCR_DIVISOR_ACCESS_SELECT])
              rd_val = divisor_high_byte[c*8+:8];
            else
              rd_val = irq_enable_reg[c*8+:8];
          end
          `UMCS_OFF_IIR: rd_val = irq_source_id_reg[c];
          `UMCS_OFF_LCR: rd_val = line_format_reg[c*8+:8];
          `UMCS_OFF_MCR: rd_val = 8'h00;
          `UMCS_OFF_LSR: rd_val = line_state[c*8+:8];
          `UMCS_OFF_MSR: begin
            rd_val    = modem_input_state_reg[c*8+:8];
            msr_rd[c] = rd_take & rd_hi_ok;
          end
          `UMCS_OFF_SCR: rd_val = scratch_reg[c*8+:8];
          default:       rd_val = 8'h00;
        endcase
      end
    end
    if (rd_idx == `UMCS_IDX_INT_STAT)
      rd_val = {6'h00, int_stat_reg};
    else if (rd_idx == `UMCS_IDX_INT_EN)
      rd_val = {6'h00, int_en_reg};
    else if (rd_idx == `UMCS_IDX_CFG)
      rd_val = {6'h00, serial_config_reg};
    if (!rd_ok)
      rd_val = 8'h00;
  end

  // Bus channels and register writes
  always @(posedge sys_clk or negedge rst_n) begin : wr_regs
    integer c;
    if (!rst_n) begin
      aw_hold_reg                  <= 1'b0;
      aw_idx_reg                   <= 16'h0000;
      aw_hi_ok_reg                 <= 1'b0;
      w_hold_reg                   <= 1'b0;
      w_data_reg                   <= 8'h00;
      w_strb_reg                   <= 1'b0;
      s_axi_bvalid                 <= 1'b0;
      s_axi_bresp                  <= `UMCS_RESP_OKAY;
      s_axi_rvalid                 <= 1'b0;
      s_axi_rresp                  <= `UMCS_RESP_OKAY;
      s_axi_rdata                  <= 32'h00000000;
      handshake_output_control_reg <= {2{`UMCS_RST_BYTE}};
      line_format_reg              <= {2{`UMCS_RST_BYTE}};
      irq_enable_reg               <= {2{`UMCS_RST_BYTE}};
      scratch_reg                  <= {2{`UMCS_RST_BYTE}};
      divisor_low_byte             <= {2{`UMCS_RST_BYTE}};
      divisor_high_byte            <= {2{`UMCS_RST_BYTE}};
      tx_data                      <= {2{`UMCS_RST_BYTE}};
      serial_config_reg            <= `UMCS_RST_PAIR;
      int_stat_reg                 <= `UMCS_RST_PAIR;
      int_en_reg                   <= `UMCS_RST_PAIR;
      tx_buf_write                 <= 2'h0;
      rx_buf_read                  <= 2'h0;
      loopback_active              <= 2'h0;
    end else begin
      tx_buf_write <= 2'h0;
      rx_buf_read  <= rbr_rd;
      loopback_active <= {handshake_output_control_reg[8+`UMCS_MCR_LOOP],
                          handshake_output_control_reg[`UMCS_MCR_LOOP]};
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg  <= 1'b1;
        aw_idx_reg   <= s_axi_awaddr[`UMCS_IDX_MSB:`UMCS_IDX_LSB];
        aw_hi_ok_reg <= ~|s_axi_awaddr[31:`UMCS_IDX_MSB+1];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `UMCS_RESP_OKAY : `UMCS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_val};
        s_axi_rresp  <= rd_ok ? `UMCS_RESP_OKAY : `UMCS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      for (c = 0; c < NCH; c = c + 1) begin
        if (wr_do && wr_hit[c]) begin
          case (aw_idx_reg[2:0])
            `UMCS_OFF_BUF: begin
              if (line_format_reg[c*8+`UMCS_LCR_DIVISOR_ACCESS_SELECT]) begin
                divisor_low_byte[c*8+:8] <= w_data_reg;
              end else begin
                tx_data[c*8+:8] <= w_data_reg;
                tx_buf_write[c] <= 1'b1;
              end
            end
            `UMCS_OFF_IER: begin
              if (line_format_reg[c*8+`UMCS_LCR_DIVISOR_ACCESS_SELECT])
                divisor_high_byte[c*8+:8] <= w_data_reg;
              else
                irq_enable_reg[c*8+:8] <= w_data_reg;
            end
            `UMCS_OFF_LCR: line_format_reg[c*8+:8] <= w_data_reg;
            `UMCS_OFF_MCR: handshake_output_control_reg[c*8+:8] <= w_data_reg;
            `UMCS_OFF_SCR: scratch_reg[c*8+:8] <= w_data_reg;
            default: ;
          endcase
        end
      end
      if (wr_do && aw_idx_reg == `UMCS_IDX_INT_EN)
        int_en_reg <= w_data_reg[1:0];
      if (wr_do && aw_idx_reg == `UMCS_IDX_CFG)
        serial_config_reg <= w_data_reg[1:0];
      // New modem changes win over a clear in the same cycle
      if (wr_do && aw_idx_reg == `UMCS_IDX_INT_CLR)
        int_stat_reg <= (int_stat_reg & ~w_data_reg[1:0]) | ms_evt;
      else
        int_stat_reg <= int_stat_reg | ms_evt;
    end
  end

endmodule

// [sim/umcs_monitor.sv]
// Bus and pin checks on the modem control and status block
`timescale 1ns/1ps
`include "umcs_map.vh"

module umcs_monitor (
  // Clock and reset
  input wire        sys_clk,
  input wire        nrst,
  // Register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Pins and core side
  input wire [1:0]  terminal_ready_n,
  input wire [1:0]  request_to_send_n,
  input wire [1:0]  rx_buf_read,
  input wire [1:0]  loopback_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_busy_block;
    s_axi_bvalid || s_axi_rvalid |-> !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready);
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("request taken while busy");
  property p_unmapped;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[31:18] != 14'h0000)
      |=> s_axi_rresp == `UMCS_RESP_SLVERR && s_axi_rdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_loop_quiet;
    loopback_active[0] [*2] |-> terminal_ready_n[0] && request_to_send_n[0];
  endproperty
  a_loop_quiet: assert property (p_loop_quiet) else $error("pins active in loopback");
  property p_rd_pulse;
    rx_buf_read[0] |=> !rx_buf_read[0];
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("buffer read pulse too long");
endmodule

bind umcs_top umcs_monitor mon_u (.sys_clk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .terminal_ready_n, .request_to_send_n, .rx_buf_read, .loopback_active);

// [sim/umcs_modem_model.sv]
// Modem partner driving the active-low handshake inputs of both channels
`timescale 1ns/1ps

module umcs_modem_model (
  // Clock
  input  wire       sys_clk,
  // Channel 0 pin levels {carrier, ring, set ready, clear to send}
  input  wire [3:0] pin_cmd,
  // Handshake outputs of the block
  input  wire [1:0] terminal_ready_n,
  input  wire [1:0] request_to_send_n,
  // Modem pins, active low
  output reg  [1:0] carrier_detect_n,
  output reg  [1:0] ring_indicator_n,
  output reg  [1:0] data_set_ready_n,
  output reg  [1:0] clear_to_send_n
);
  initial begin
    {carrier_detect_n, ring_indicator_n, data_set_ready_n, clear_to_send_n} = 8'hFF;
  end
  // Channel 1 echoes its handshake like a real modem, one clock late
  always @(posedge sys_clk) begin
    {carrier_detect_n[0], ring_indicator_n[0], data_set_ready_n[0], clear_to_send_n[0]} <= pin_cmd;
    carrier_detect_n[1] <= 1'b1;
    ring_indicator_n[1] <= 1'b1;
    data_set_ready_n[1] <= terminal_ready_n[1];
    clear_to_send_n[1]  <= request_to_send_n[1];
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench of the modem control and status block
`timescale 1ns/1ps

module testbench;
  localparam logic [31:0] A_BUF0 = 32'h0003D3E0, A_IER0 = 32'h0003D3E4, A_IIR0 = 32'h0003D3E8;
  localparam logic [31:0] A_LCR0 = 32'h0003D3EC, A_MCR0 = 32'h0003D3F0, A_MODEM_INPUT_STATE_CH0 = 32'h0003D3F8;
  localparam logic [31:0] A_SCRATCH_CH0 = 32'h0003D3FC, A_SCRATCH_CH1 = 32'h0003E3FC, A_STAT = 32'h0003E400;
  localparam logic [31:0] A_EN = 32'h0003E404, A_CLR = 32'h0003E408, A_CFG = 32'h0003E40C;
  localparam logic [31:0] A_BAD = 32'h00100000, A_MCR1 = 32'h0003E3F0, A_MODEM_INPUT_STATE_CH1 = 32'h0003E3F8;
  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  wdat;
    logic [7:0]  rdat;
    logic [1:0]  wrsp;
    logic [1:0]  rrsp;
  } umcs_row_t;
  logic sys_clk = 1'b0, nrst = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rd_val;
  logic [3:0]  s_axi_wstrb = 4'hF, pin_cmd = 4'hF;
  logic [15:0] rx_data = 16'h0000, line_state = 16'h0000;
  logic [1:0]  rx_buf_full = 2'h0, tx_buf_empty = 2'h0, rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp, carrier_detect_n, ring_indicator_n, data_set_ready_n;
  wire [1:0] clear_to_send_n, terminal_ready_n, request_to_send_n, rx_buf_read, tx_buf_write;
  wire [1:0] loopback_active, serial_irq_request;
  wire [15:0] tx_data, line_format;
  wire [31:0] s_axi_rdata, divisor;
  int bad_count = 0, tests_run = 0;
  umcs_row_t rows [6] = '{'{A_SCRATCH_CH0, 8'hA5, 8'hA5, 2'h0, 2'h0}, '{A_SCRATCH_CH0, 8'hFF, 8'hFF, 2'h0, 2'h0},
    '{A_SCRATCH_CH1, 8'h3C, 8'h3C, 2'h0, 2'h0}, '{A_EN, 8'h01, 8'h01, 2'h0, 2'h0},
    '{A_MCR0, 8'h00, 8'h00, 2'h0, 2'h0}, '{A_BAD, 8'h5A, 8'h00, 2'h2, 2'h2}};
  logic [3:0]  pin_seq [6] = '{4'h7, 4'h3, 4'h7, 4'h5, 4'h4, 4'h4};
  logic [7:0]  msr_seq [6] = '{8'h88, 8'hC0, 8'h84, 8'hA2, 8'hB1, 8'hB0};
  // {enable, rx full, tx empty, line error, request, source id}
  logic [19:0] iir_rows [6] = '{{8'h08, 4'h0, 8'h01}, {8'h01, 4'h9, 8'h04}, {8'h03, 4'hD, 8'h04},
    {8'h02, 4'hD, 8'h02}, {8'h07, 4'hF, 8'h06}, {8'h00, 4'hE, 8'h01}};

  umcs_top dut_u (.sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .carrier_detect_n, .ring_indicator_n, .data_set_ready_n, .clear_to_send_n,
    .terminal_ready_n, .request_to_send_n, .rx_data, .line_state, .rx_buf_full, .tx_buf_empty,
    .rx_buf_read, .tx_data, .tx_buf_write, .loopback_active, .divisor, .line_format,
    .serial_irq_request, .irq);
  umcs_modem_model modem_u (.sys_clk, .pin_cmd, .terminal_ready_n, .request_to_send_n,
    .carrier_detect_n, .ring_indicator_n, .data_set_ready_n, .clear_to_send_n);

  always #50 sys_clk = ~sys_clk;

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // A wait that runs out ends the run rather than hanging it
  task automatic tmo(input int n);
    if (n >= 200) begin
      bad_count++;
      $display("ERROR %0t bus wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    bit aw_ok, w_ok;
    @(posedge sys_clk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_bready <= 1'b1;
    s_axi_wdata <= {24'h000000, d}; s_axi_wvalid <= 1'b1;
    aw_ok = 1'b0; w_ok = 1'b0;
    for (n = 0; n < 200 && !(aw_ok && w_ok); n++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) begin aw_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wvalid && s_axi_wready) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    tmo(n);
    for (n = 0; n < 200 && !s_axi_bvalid; n++) @(posedge sys_clk);
    tmo(n);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (s_axi_arready) break;
    end
    tmo(n);
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 200 && !s_axi_rvalid; n++) @(posedge sys_clk);
    tmo(n);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wrt(input logic [31:0] a, input logic [7:0] d);
    wr(a, d, rsp);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [7:0] e);
    rd(a, rd_val, rsp);
    chk(rd_val, {24'h000000, e});
  endtask

  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdat, rsp);
      chk(rsp, rows[i].wrsp);
      rd(rows[i].addr, rd_val, rsp);
      chk(rsp, rows[i].rrsp);
      chk(rd_val, {24'h000000, rows[i].rdat});
    end
    rchk(A_IER0, 8'h00);
    rchk(A_IIR0, 8'h01);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'h00);
    foreach (pin_seq[i]) begin
      pin_cmd <= pin_seq[i];
      repeat (6) @(posedge sys_clk);
      rchk(A_MODEM_INPUT_STATE_CH0, msr_seq[i]);
    end
    @(negedge sys_clk);
    chk(irq, 1'b1);
    rchk(A_STAT, 8'h01);
    wrt(A_CLR, 8'h01);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    wrt(A_EN, 8'h00);
    for (int v = 0; v < 4; v++) begin
      wrt(A_MCR0, v[7:0]);
      @(negedge sys_clk);
      chk({request_to_send_n[0], terminal_ready_n[0]}, {~v[1], ~v[0]});
    end
    wrt(A_MCR0, 8'h1F);
    @(negedge sys_clk);
    chk({loopback_active[0], request_to_send_n[0], terminal_ready_n[0]}, 3'h7);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'hF0);
    wrt(A_MCR0, 8'h10);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'h0F);
    wrt(A_MCR0, 8'h11);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'h22);
    chk(irq, 1'b0);
    rchk(A_STAT, 8'h01);
    wrt(A_MCR0, 8'h00);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'hB9);
    wrt(A_CFG, 8'h01);
    wrt(A_MCR0, 8'h01);
    @(negedge sys_clk);
    chk({request_to_send_n[0], terminal_ready_n[0]}, 2'h2);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'hAB);
    wrt(A_CFG, 8'h00);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'hB1);
    wrt(A_LCR0, 8'h80);
    wrt(A_BUF0, 8'h12);
    wrt(A_IER0, 8'h34);
    @(negedge sys_clk);
    chk(divisor[15:0], 16'h3412);
    rchk(A_BUF0, 8'h12);
    wrt(A_LCR0, 8'h03);
    rx_data <= 16'h0077;
    rchk(A_BUF0, 8'h77);
    wrt(A_BUF0, 8'h56);
    @(negedge sys_clk);
    chk({line_format[7:0], tx_data[7:0], divisor[15:0]}, 32'h03563412);
    foreach (iir_rows[i]) begin
      wrt(A_IER0, iir_rows[i][19:12]);
      rx_buf_full[0] <= iir_rows[i][11];
      tx_buf_empty[0] <= iir_rows[i][10];
      line_state[7:0] <= {6'h00, iir_rows[i][9], 1'b0};
      @(negedge sys_clk);
      chk(serial_irq_request[0], iir_rows[i][8]);
      rchk(A_IIR0, iir_rows[i][7:0]);
    end
    // Clear-to-send change timed to land on the edge that takes the status read
    pin_cmd <= 4'h5;
    repeat (2) @(posedge sys_clk);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'hB0);
    wrt(A_IER0, 8'h08);
    @(negedge sys_clk);
    chk(serial_irq_request[0], 1'b1);
    rchk(A_IIR0, 8'h00);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'hA1);
    wrt(A_MCR1, 8'h03);
    repeat (4) @(posedge sys_clk);
    rchk(A_MODEM_INPUT_STATE_CH1, 8'h33);
    // Mid-run reset: pins go inactive at once, active pins flag again after release
    nrst <= 1'b0;
    @(negedge sys_clk);
    chk({loopback_active[0], request_to_send_n, terminal_ready_n, irq}, 6'h1E);
    @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rchk(A_MODEM_INPUT_STATE_CH0, 8'hAA);
    rchk(A_IIR0, 8'h01);
    wrap_up();
  end
endmodule
